// >>> design/fault_supervisor_pkg.sv
// Behaviour
// - every diagnostic fault latches and holds until clear or power cycle; secondary over current until power cycle only
// - clear by panel key on internal control, external line on external
// - power cycle (reset) clears every latched indication
// - external start, stop, clear, arm act like panel keys only when external
// - open interlock lights interlock indicator and shuts output off
// - interlock input checked only when external interlock option enabled
// - regulate on lower of voltage or current setting, report active mode
// - soft-start restarts at power-on and on any diagnostic trip
// - standby is normal off state; start leaves it, stop returns
// - reference above bound raises program-range fault and disables output
// - over voltage shuts down and latches; resume needs clear then start
// - over current shuts down and latches; resume needs clear then start
// - secondary over current ignores clear, released only by power cycle
// - separate latch for thermal, interlock, phase, range, fuse, ov, oc
// - alarm output and indicator assert while any fault latched
// - standby-or-alarm output asserts in standby or on alarm
// - each status output driven high while its condition is active
// - status outputs for int control, ext control, voltage and current mode
// - any reference over upper limit lights program-line and turns output off
package fault_supervisor_pkg;

    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
    localparam logic [7:0]  CMD_OFFSET     = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET  = 8'h08;
    localparam logic [7:0]  FAULT_OFFSET   = 8'h0C;
    localparam logic [7:0]  REFLIM_OFFSET  = 8'h10;

    // ctrl fields
    localparam int          CTRL_EXT_BIT   = 0;
    localparam int          CTRL_ILK_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h0;

    // cmd fields, write-one pulses standing for the panel keys
    localparam int          CMD_START_BIT  = 0;
    localparam int          CMD_STOP_BIT   = 1;
    localparam int          CMD_CLEAR_BIT  = 2;
    localparam int          CMD_ARM_BIT    = 3;

    // fault vector positions
    localparam int          NUM_FAULTS     = 8;
    localparam int          F_THERMAL      = 0;
    localparam int          F_INTERLOCK    = 1;
    localparam int          F_PHASE        = 2;
    localparam int          F_RANGE        = 3;
    localparam int          F_FUSE         = 4;
    localparam int          F_OVERV        = 5;
    localparam int          F_OVERI        = 6;
    localparam int          F_SECOVERI     = 7;

    // references: 12-bit codes, full scale 10.0 V = 12'h0CCC, limit 12.50 V
    localparam int          REF_W          = 12;
    localparam logic [11:0] REF_LIMIT_RST  = 12'h0FFF;

    // soft start: 10 ms ramp at 100 MHz
    localparam int          CLK_MHZ        = 100;
    localparam int          SOFT_START_US  = 10000;
    localparam int          SOFT_START_CYC = SOFT_START_US * CLK_MHZ;

    typedef enum logic [1:0] {ST_STANDBY, ST_RAMP, ST_RUN} run_state_e;

endpackage : fault_supervisor_pkg

// >>> design/fault_supervisor_control.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module fault_supervisor_control #(
    parameter int SOFT_START_CYCLES = fault_supervisor_pkg::SOFT_START_CYC
) (
    input  wire logic                                 mclk,
    input  wire logic                                 rst_n,
    // apb slave
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [7:0]                           paddr,
    input  wire logic [31:0]                          pwdata,
    output logic      [31:0]                          prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    // external digital lines, asynchronous
    input  wire logic                                 extStart,
    input  wire logic                                 extStop,
    input  wire logic                                 extClear,
    input  wire logic                                 extArm,
    input  wire logic                                 interlockSet,
    // analog comparators and sensors, asynchronous
    input  wire logic                                 thermalTrip,
    input  wire logic                                 phaseLoss,
    input  wire logic                                 fuseOpen,
    input  wire logic                                 overVoltTrip,
    input  wire logic                                 overCurTrip,
    input  wire logic                                 secOverCurTrip,
    input  wire logic                                 voltLimiting,
    // reference input codes, from an adc on mclk
    input  wire logic [fault_supervisor_pkg::REF_W-1:0] voltRef,
    input  wire logic [fault_supervisor_pkg::REF_W-1:0] curRef,
    input  wire logic [fault_supervisor_pkg::REF_W-1:0] ovTripRef,
    input  wire logic [fault_supervisor_pkg::REF_W-1:0] ocTripRef,
    // outputs
    output logic                                      contactorOn,
    output logic                                      softStartRun,
    output logic                                      armed,
    output logic                                      standbyOut,
    output logic                                      alarmOut,
    output logic                                      standbyOrAlarm,
    output logic                                      intCtlOut,
    output logic                                      extCtlOut,
    output logic                                      voltCtlOut,
    output logic                                      curCtlOut,
    output logic [fault_supervisor_pkg::NUM_FAULTS-1:0] faultOut
);
    import fault_supervisor_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] asyncIn;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    logic [3:0]       extPrev;

    assign asyncIn = {voltLimiting, secOverCurTrip, overCurTrip, overVoltTrip, fuseOpen,
                      phaseLoss, thermalTrip, interlockSet, extArm, extClear, extStop, extStart};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            syncA   <= '0;
            syncB   <= '0;
            extPrev <= '0;
        end else begin
            syncA   <= asyncIn;
            syncB   <= syncA;
            extPrev <= syncB[3:0];
        end
    end

    wire logic [3:0] extRise   = syncB[3:0] & ~extPrev;
    wire logic       ilkClosed = syncB[4];
    wire logic       voltMode  = syncB[11];

    // ------------------------------------------------------------
    // registers and apb
    // ------------------------------------------------------------
    logic [1:0]       ctrl;
    logic [REF_W-1:0] refLimit;
    logic [NUM_FAULTS-1:0] faults;
    run_state_e       state;
    run_state_e       next_state;
    logic [31:0]      ssCount;
    logic             armReg;

    wire logic extMode  = ctrl[CTRL_EXT_BIT];
    wire logic ilkEn    = ctrl[CTRL_ILK_BIT];
    wire logic apbWr    = psel & penable & pwrite;
    wire logic apbSetRd = psel & ~penable & ~pwrite;
    wire logic hitCtrl  = (paddr == CTRL_OFFSET);
    wire logic hitCmd   = (paddr == CMD_OFFSET);
    wire logic hitStat  = (paddr == STATUS_OFFSET);
    wire logic hitFault = (paddr == FAULT_OFFSET);
    wire logic hitLim   = (paddr == REFLIM_OFFSET);
    wire logic mapped   = hitCtrl | hitCmd | hitStat | hitFault | hitLim;
    wire logic [3:0] panelKey = (apbWr && hitCmd) ? pwdata[3:0] : 4'h0;

    // key sources switch with control mode; the other source is dead
    wire logic [3:0] key      = extMode ? extRise : panelKey;
    wire logic startCmd = key[CMD_START_BIT];
    wire logic stopCmd  = key[CMD_STOP_BIT];
    wire logic clearCmd = key[CMD_CLEAR_BIT];
    wire logic armCmd   = key[CMD_ARM_BIT];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= CTRL_RESET;
            refLimit <= REF_LIMIT_RST;
        end else if (apbWr && hitCtrl) begin
            ctrl     <= pwdata[1:0];
        end else if (apbWr && hitLim) begin
            refLimit <= pwdata[REF_W-1:0];
        end
    end

    wire logic [31:0] statusWord = {24'h0, voltMode, ~voltMode, extMode, ~extMode,
                                    alarmOut, armReg, 2'(state)};
    wire logic [31:0] rdMux = hitCtrl  ? {30'h0, ctrl} :
                              hitStat  ? statusWord :
                              hitFault ? {24'h0, faults} :
                              hitLim   ? {20'h0, refLimit} : 32'h0000_0000;

    // loaded in setup: pready is always high, so data must stand at the access edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apbSetRd) begin
            prdata <= rdMux;
        end
    end

    // ------------------------------------------------------------
    // fault latches
    // ------------------------------------------------------------
    function automatic logic overLimit(input logic [REF_W-1:0] v, input logic [REF_W-1:0] lim);
        overLimit = (v > lim);
    endfunction : overLimit

    wire logic rangeBad = overLimit(voltRef, refLimit) | overLimit(curRef, refLimit) |
                          overLimit(ovTripRef, refLimit) | overLimit(ocTripRef, refLimit);
    wire logic [NUM_FAULTS-1:0] cause;
    assign cause[F_THERMAL]   = syncB[5];
    assign cause[F_INTERLOCK] = ilkEn & ~ilkClosed;
    assign cause[F_PHASE]     = syncB[6];
    assign cause[F_RANGE]     = rangeBad;
    assign cause[F_FUSE]      = syncB[7];
    assign cause[F_OVERV]     = syncB[8];
    assign cause[F_OVERI]     = syncB[9];
    assign cause[F_SECOVERI]  = syncB[10];

    // clear mask leaves secondary trip alone
    logic [NUM_FAULTS-1:0] clrMask;
    assign clrMask = clearCmd ? {1'b0, {(NUM_FAULTS-1){1'b1}}} : '0;

    // set wins over clear; reset is the power cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            faults <= '0;
        end else begin
            faults <= (faults & ~clrMask) | cause;
        end
    end

    wire logic anyFault = |faults;
    wire logic newTrip  = |(cause & ~faults);

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_STANDBY: begin
                if (startCmd && !anyFault && !newTrip) begin
                    next_state = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (stopCmd || anyFault || newTrip) begin
                    next_state = ST_STANDBY;
                end else if (ssCount >= SOFT_START_CYCLES - 1) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stopCmd || anyFault || newTrip) begin
                    next_state = ST_STANDBY;
                end
            end
            default: next_state = ST_STANDBY;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_STANDBY;
            ssCount <= 32'h0000_0000;
            armReg  <= 1'b0;
        end else begin
            state   <= next_state;
            // ramp starts over after any trip or stop
            ssCount <= (next_state == ST_RAMP && state == ST_RAMP) ? ssCount + 32'h0000_0001
                                                                   : 32'h0000_0000;
            if (armCmd) begin
                armReg <= ~armReg;
            end
        end
    end

    // ------------------------------------------------------------
    // status outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            contactorOn    <= 1'b0;
            softStartRun   <= 1'b0;
            armed          <= 1'b0;
            standbyOut     <= 1'b1;
            alarmOut       <= 1'b0;
            standbyOrAlarm <= 1'b1;
            intCtlOut      <= 1'b1;
            extCtlOut      <= 1'b0;
            voltCtlOut     <= 1'b0;
            curCtlOut      <= 1'b0;
            faultOut       <= '0;
        end else begin
            contactorOn    <= (next_state != ST_STANDBY);
            softStartRun   <= (next_state == ST_RAMP);
            armed          <= armReg;
            standbyOut     <= (next_state == ST_STANDBY);
            alarmOut       <= anyFault;
            standbyOrAlarm <= (next_state == ST_STANDBY) | anyFault;
            intCtlOut      <= ~extMode;
            extCtlOut      <= extMode;
            voltCtlOut     <= (state != ST_STANDBY) & voltMode;
            curCtlOut      <= (state != ST_STANDBY) & ~voltMode;
            faultOut       <= faults;
        end
    end

endmodule : fault_supervisor_control

// >>> bench/ext_terminal_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// rear terminal lines, driven like a remote controller
// ------------------------------------------------------------
module ext_terminal_model
    import fault_supervisor_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [3:0] keyReq,
    input  wire logic       ilkClosed,
    output logic            extStart,
    output logic            extStop,
    output logic            extClear,
    output logic            extArm,
    output logic            interlockSet
);
    logic [3:0] lines = 4'h0;
    int         hold  = 0;
    // held 5 cycles so the two-stage sync plus edge detect sees it
    always @(posedge mclk) begin
        if (keyReq != 4'h0) begin
            lines <= keyReq;
            hold  <= 4;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end else begin
            lines <= 4'h0;
        end
    end
    assign extStart     = lines[CMD_START_BIT];
    assign extStop      = lines[CMD_STOP_BIT];
    assign extClear     = lines[CMD_CLEAR_BIT];
    assign extArm       = lines[CMD_ARM_BIT];
    assign interlockSet = ilkClosed;
endmodule : ext_terminal_model

// >>> bench/fault_supervisor_asserts.sv
`timescale 1ns/1ps
module fault_supervisor_asserts
    import fault_supervisor_pkg::*;
#(
    parameter int SOFT_START_CYCLES = 8
) (
    input wire logic                  mclk,
    input wire logic                  rst_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [7:0]            paddr,
    input wire logic                  pslverr,
    input wire logic                  contactorOn,
    input wire logic                  softStartRun,
    input wire logic                  standbyOut,
    input wire logic                  alarmOut,
    input wire logic                  standbyOrAlarm,
    input wire logic                  intCtlOut,
    input wire logic                  extCtlOut,
    input wire logic                  voltCtlOut,
    input wire logic                  curCtlOut,
    input wire logic [NUM_FAULTS-1:0] faultOut
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic badAddr;
    assign badAddr = !(paddr inside {CTRL_OFFSET, CMD_OFFSET, STATUS_OFFSET, FAULT_OFFSET, REFLIM_OFFSET});
    sequence s_rampStart;
        $rose(contactorOn) ##0 softStartRun;
    endsequence
    // cycles spent in the current ramp
    int rampLen;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rampLen <= 0;
        end else begin
            rampLen <= softStartRun ? rampLen + 1 : 0;
        end
    end
    property p_rampLen; ($fell(softStartRun) && contactorOn) |-> (rampLen == SOFT_START_CYCLES); endproperty
    a_rampLen: assert property (p_rampLen) else $error("ramp length wrong");
    property p_alarm; alarmOut == (|faultOut); endproperty
    a_alarm: assert property (p_alarm) else $error("alarm differs from fault set");
    property p_sba; (standbyOut || alarmOut) |-> ##[0:1] standbyOrAlarm; endproperty
    a_sba: assert property (p_sba) else $error("standby-or-alarm low");
    property p_faultOff; (|faultOut) |-> ##[0:2] !contactorOn; endproperty
    a_faultOff: assert property (p_faultOff) else $error("output on with fault");
    property p_secHold; !$fell(faultOut[F_SECOVERI]); endproperty
    a_secHold: assert property (p_secHold) else $error("secondary trip released");
    property p_ctlSrc; intCtlOut != extCtlOut; endproperty
    a_ctlSrc: assert property (p_ctlSrc) else $error("control source outputs clash");
    property p_mode; !(voltCtlOut && curCtlOut); endproperty
    a_mode: assert property (p_mode) else $error("both regulation modes shown");
    property p_standby; standbyOut |-> !contactorOn; endproperty
    a_standby: assert property (p_standby) else $error("contactor on in standby");
    property p_ramp; $rose(contactorOn) |-> s_rampStart; endproperty
    a_ramp: assert property (p_ramp) else $error("output on without ramp");
    property p_tripRamp; $rose(|faultOut) |-> ##[0:2] !softStartRun; endproperty
    a_tripRamp: assert property (p_tripRamp) else $error("ramp kept after trip");
    property p_noStart; ((|faultOut) && !contactorOn) |=> !contactorOn; endproperty
    a_noStart: assert property (p_noStart) else $error("started with fault latched");
    property p_err; (psel && penable && badAddr) |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped access");
endmodule : fault_supervisor_asserts

bind fault_supervisor_control fault_supervisor_asserts #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) chk_i (
    .mclk, .rst_n, .psel, .penable, .paddr, .pslverr, .contactorOn, .softStartRun, .standbyOut,
    .alarmOut, .standbyOrAlarm, .intCtlOut, .extCtlOut, .voltCtlOut, .curCtlOut, .faultOut);

// >>> bench/tb_fault_supervisor_control.sv
`timescale 1ns/1ps
module tb_fault_supervisor_control;
    import fault_supervisor_pkg::*;
    logic        mclk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, voltLim = 1'h0, ilk = 1'h1, contactorOn, softStartRun, armed;
    logic        standbyOut, alarmOut, standbyOrAlarm, intCtlOut, extCtlOut, voltCtlOut, curCtlOut;
    logic        extStart, extStop, extClear, extArm, interlockSet;
    logic [3:0]  keyReq = 4'h0;
    logic [5:0]  cause = 6'h00;
    logic [11:0] curRef = 12'h000, ocRef = 12'h000;
    logic [7:0]  faultOut;
    int          badCount = 0, nTests = 0, cyc = 0;
    localparam int ROW_BIT [5] = '{F_THERMAL, F_PHASE, F_FUSE, F_OVERV, F_OVERI};

    fault_supervisor_control #(.SOFT_START_CYCLES(8)) fault_supervisor_control_i (
        .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .extStart, .extStop, .extClear, .extArm, .interlockSet, .thermalTrip(cause[0]), .phaseLoss(cause[1]),
        .fuseOpen(cause[2]), .overVoltTrip(cause[3]), .overCurTrip(cause[4]), .secOverCurTrip(cause[5]),
        .voltLimiting(voltLim), .voltRef(12'h000), .curRef, .ovTripRef(12'h000), .ocTripRef(ocRef),
        .contactorOn, .softStartRun, .armed, .standbyOut, .alarmOut, .standbyOrAlarm, .intCtlOut,
        .extCtlOut, .voltCtlOut, .curCtlOut, .faultOut);
    ext_terminal_model ext_terminal_model_i (.mclk, .keyReq, .ilkClosed(ilk), .extStart, .extStop,
        .extClear, .extArm, .interlockSet);

    initial begin
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finalReport();
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finalReport
    // answer taken at the access edge; one idle cycle follows
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask : apb
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    task automatic trip(input logic [5:0] c);
        cause <= c;
        wt(3);
        cause <= 6'h00;
        wt(6);
    endtask : trip
    task automatic key(input logic [3:0] k);
        keyReq <= k;
        wt(1);
        keyReq <= 4'h0;
        wt(10);
    endtask : key
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            badCount++;
            finalReport();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        wt(10);
        rst_n <= 1'h1;
        wt(2);
        chk("standby", 1, standbyOut);
        for (int r = 0; r < 5; r++) begin
            trip(6'h01 << r);
            chk("fault", 32'h1 << ROW_BIT[r], {24'h0, faultOut});
            chk("alarm", 1, alarmOut);
            apb(1'h1, CMD_OFFSET, 32'h0000_0004);
            wt(3);
            chk("cleared", 0, {24'h0, faultOut});
        end
        apb(1'h1, CMD_OFFSET, 32'h0000_0001);
        chk("ramp", 1, softStartRun);
        wt(12);
        chk("run", 1, contactorOn && !softStartRun);
        voltLim <= 1'h1;
        wt(4);
        chk("vmode", 2'h2, {voltCtlOut, curCtlOut});
        voltLim <= 1'h0;
        wt(4);
        chk("imode", 2'h1, {voltCtlOut, curCtlOut});
        trip(6'h08);
        chk("ov off", 2'h1, {contactorOn, standbyOrAlarm});
        apb(1'h1, CMD_OFFSET, 32'h0000_0001);
        wt(3);
        chk("start ignored", 0, contactorOn);
        apb(1'h1, CMD_OFFSET, 32'h0000_0004);
        wt(3);
        chk("clear no run", 0, contactorOn);
        apb(1'h1, CMD_OFFSET, 32'h0000_0001);
        wt(1);
        chk("restart", 1, softStartRun);
        apb(1'h1, CMD_OFFSET, 32'h0000_0002);
        wt(2);
        chk("stopped", 1, standbyOut);
        apb(1'h1, REFLIM_OFFSET, 32'h0000_0800);
        curRef <= 12'h800;
        wt(6);
        chk("at limit", 0, {24'h0, faultOut});
        curRef <= 12'h801;
        wt(6);
        chk("range", 1, faultOut[F_RANGE]);
        apb(1'h0, FAULT_OFFSET, 32'h0000_0000);
        chk("fault rd", 32'h0000_0008, rd);
        apb(1'h0, REFLIM_OFFSET, 32'h0000_0000);
        chk("limit rd", 32'h0000_0800, rd);
        curRef <= 12'h000;
        ocRef  <= 12'h801;
        apb(1'h1, CMD_OFFSET, 32'h0000_0004);
        wt(3);
        chk("oc range", 1, faultOut[F_RANGE]);
        ocRef  <= 12'h000;
        apb(1'h1, CMD_OFFSET, 32'h0000_0004);
        apb(1'h1, CTRL_OFFSET, 32'h0000_0001);
        wt(3);
        chk("ext src", 2'h1, {intCtlOut, extCtlOut});
        apb(1'h1, CMD_OFFSET, 32'h0000_0001);
        wt(3);
        chk("panel ignored", 0, contactorOn);
        key(4'h1);
        chk("ext start", 1, contactorOn);
        key(4'h2);
        key(4'h8);
        chk("ext stop arm", 2'h3, {standbyOut, armed});
        apb(1'h0, STATUS_OFFSET, 32'h0000_0000);
        chk("status rd", 32'h0000_0064, rd);
        ilk <= 1'h0;
        wt(6);
        chk("ilk unchecked", 0, {24'h0, faultOut});
        apb(1'h1, CTRL_OFFSET, 32'h0000_0003);
        wt(6);
        chk("ilk open", 1, faultOut[F_INTERLOCK]);
        ilk <= 1'h1;
        key(4'h4);
        chk("ext clear", 0, {24'h0, faultOut});
        apb(1'h0, 8'h40, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {31'h0, err});
        chk("unmapped rd", 0, rd);
        apb(1'h1, CTRL_OFFSET, 32'h0000_0000);
        trip(6'h20);
        apb(1'h1, CMD_OFFSET, 32'h0000_0004);
        wt(3);
        chk("sec held", 32'h80, {24'h0, faultOut});
        rst_n <= 1'h0;
        wt(2);
        rst_n <= 1'h1;
        wt(3);
        chk("power cycle", 32'h1, {23'h0, faultOut, standbyOut});
        finalReport();
    end
endmodule : tb_fault_supervisor_control
